/* inc/dpas_pkg.sv */
package dpas_pkg;

  // Core clock rate
  localparam int CLK_MHZ = 200;
  localparam int NS_PER_US = 1000;
  localparam int SYNC_STAGES = 2;

  // Pin timing defaults in ns; tune to the speed grade of the part
  localparam int FLAG_SETTLE_NS = 20;
  localparam int TOKEN_RECOVERY_NS = 15;
  localparam int ACCESS_NS = 35;
  localparam int SETUP_NS = 5;

  // Register indexes on the software port
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_BYTES = 4'h5;

  // Command register layout
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_CODE_W = 3;

  // Status register bits
  localparam int ST_RUN = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TOKEN = 2;
  localparam int ST_MAIL = 3;
  localparam int ST_CONTEND = 4;

  // Byte enable register bits
  localparam int BE_LOW = 0;
  localparam int BE_HIGH = 1;
  localparam logic [1:0] BYTES_RESET = 2'h3;

  // Commands
  localparam logic [2:0] CMD_MEM_WRITE = 3'h0;
  localparam logic [2:0] CMD_MEM_READ = 3'h1;
  localparam logic [2:0] CMD_TOKEN_TAKE = 3'h2;
  localparam logic [2:0] CMD_TOKEN_GIVE = 3'h3;
  localparam logic [2:0] CMD_TOKEN_READ = 3'h4;
  localparam logic [2:0] CMD_MAIL_POST = 3'h5;
  localparam logic [2:0] CMD_MAIL_TAKE = 3'h6;

  // Latch index width on the address pins
  localparam int TOKEN_IDX_W = 3;

  typedef enum logic [2:0] {
    DPAS_IDLE,
    DPAS_SETTLE,
    DPAS_STROBE,
    DPAS_RELEASE,
    DPAS_RECOVER
  } dpas_state_e;

  // Least time in ns to whole core cycles, never below one
  function automatic logic [15:0] dpas_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    if (c < 1)
      c = 1;
    return 16'(c);
  endfunction

endpackage

/* rtl/dpas_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module dpas_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // Reset to the idle level of the flags so no false edge follows reset
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } dpas_sync_s;

  dpas_sync_s cur;
  dpas_sync_s next_cur;

  always_comb
  begin
    next_cur.stage1 = async_in;
    next_cur.stage2 = cur.stage1;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      cur <= '1;
    else
      cur <= next_cur;
  end

  assign sync_out = cur.stage2;

endmodule // dpas_sync

`default_nettype wire

/* rtl/dpas_port_ctrl.sv */
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - System wires master contention flag output to every slave's flag input.
// - Controller waits for the contention flag to settle before any memory access; token accesses wait only the address setup time.
// - Token select acts as chip select; controller keeps chip select high then.
// - Controller deasserts token select for recovery time before reading back.
module dpas_port_ctrl
  import dpas_pkg::*;
#(
  parameter int DW = 16,
  parameter int AW = 13,
  parameter bit LEFT_PORT = 1'b1,
  parameter int SETTLE_NS = dpas_pkg::FLAG_SETTLE_NS,
  parameter int RECOVERY_NS = dpas_pkg::TOKEN_RECOVERY_NS,
  parameter int STROBE_NS = dpas_pkg::ACCESS_NS,
  parameter int ADDR_SETUP_NS = dpas_pkg::SETUP_NS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Software register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Port control pins, all active low, then the address pins
  output logic chip_select_n,
  output logic read_write_n,
  output logic output_enable_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n,
  output logic token_latch_select_n,
  output logic [AW-1:0] mem_addr,
  // Data pins
  output logic [DW-1:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [DW-1:0] mem_data_in,
  // Flags from the device, active low
  input wire logic contention_flag_n,
  input wire logic mailbox_flag_n
);
  import dpas_pkg::*;

  localparam int HALF = DW / 2;
  localparam logic [15:0] SETTLE_CYC = 16'(dpas_cycles(SETTLE_NS) + 16'(SYNC_STAGES));
  localparam logic [15:0] RECOVER_CYC = dpas_cycles(RECOVERY_NS);
  localparam logic [15:0] STROBE_CYC = 16'(dpas_cycles(STROBE_NS) + 16'(SYNC_STAGES));
  localparam logic [15:0] SETUP_CYC = dpas_cycles(ADDR_SETUP_NS);
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef struct packed {
    dpas_state_e st;
    logic [15:0] cnt;
    logic is_write;
    logic is_token;
    logic read_back;
    logic take;
    logic [AW-1:0] addr_r;
    logic [DW-1:0] wdata_r;
    logic [1:0] bytes_r;
    logic [DW-1:0] rdata_r;
    logic done;
    logic token;
    logic contended;
    logic ce_n;
    logic rw_n;
    logic oe_n;
    logic ub_n;
    logic lb_n;
    logic sem_n;
    logic [AW-1:0] pin_addr;
    logic [DW-1:0] dout;
    logic dout_oe;
    logic [31:0] bus_rdata;
  } dpas_ctrl_s;

  dpas_ctrl_s cur;
  dpas_ctrl_s next_cur;

  logic [DW-1:0] din_s;
  logic busy_n_s;
  logic mail_n_s;

  // Mailbox word at the top of the array; own box is top-1 for the left port
  function automatic logic [AW-1:0] mailbox_addr(input logic own);
    logic [AW-1:0] top;
    top = '1;
    if (own == LEFT_PORT)
      return AW'(top - AW'(1));
    return top;
  endfunction

  function automatic logic [31:0] status_word(input dpas_ctrl_s s, input logic mail_n);
    logic [31:0] w;
    w = '0;
    w[ST_RUN] = (s.st != DPAS_IDLE);
    w[ST_DONE] = s.done;
    w[ST_TOKEN] = s.token;
    w[ST_MAIL] = ~mail_n;
    w[ST_CONTEND] = s.contended;
    return w;
  endfunction

  dpas_sync #(
    .W(DW + 2)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({contention_flag_n, mailbox_flag_n, mem_data_in}),
    .sync_out({busy_n_s, mail_n_s, din_s})
  );

  always_comb
  begin
    next_cur = cur;
    next_cur.bus_rdata = '0;

    // Register reads answer in the following cycle only
    if (reg_rd)
    begin
      case (reg_addr)
        REG_ADDR: next_cur.bus_rdata = 32'(cur.addr_r);
        REG_WDATA: next_cur.bus_rdata = 32'(cur.wdata_r);
        REG_STATUS: next_cur.bus_rdata = status_word(cur, mail_n_s);
        REG_RDATA: next_cur.bus_rdata = 32'(cur.rdata_r);
        REG_BYTES: next_cur.bus_rdata = 32'(cur.bytes_r);
        default: next_cur.bus_rdata = '0;
      endcase
    end

    if (reg_wr)
    begin
      case (reg_addr)
        REG_ADDR: next_cur.addr_r = reg_wdata[AW-1:0];
        REG_WDATA: next_cur.wdata_r = reg_wdata[DW-1:0];
        REG_BYTES: next_cur.bytes_r = reg_wdata[1:0];
        REG_STATUS:
        begin
          if (reg_wdata[ST_DONE])
            next_cur.done = 1'b0;
          if (reg_wdata[ST_CONTEND])
            next_cur.contended = 1'b0;
        end
        default: ;
      endcase
    end

    case (cur.st)
      DPAS_IDLE:
      begin
        if (reg_wr && reg_addr == REG_CMD)
        begin
          next_cur.st = DPAS_SETTLE;
          next_cur.done = 1'b0;
          next_cur.take = 1'b0;
          next_cur.read_back = 1'b0;
          next_cur.oe_n = 1'b1;
          next_cur.rw_n = 1'b1;
          next_cur.dout = cur.wdata_r;
          next_cur.dout_oe = 1'b0;
          next_cur.ub_n = ~cur.bytes_r[BE_HIGH];
          next_cur.lb_n = ~cur.bytes_r[BE_LOW];
          next_cur.pin_addr = cur.addr_r;
          case (reg_wdata[CMD_CODE_LSB +: CMD_CODE_W])
            CMD_MEM_WRITE, CMD_MAIL_POST:
            begin
              next_cur.is_write = 1'b1;
              next_cur.is_token = 1'b0;
              next_cur.dout_oe = 1'b1;
              if (reg_wdata[CMD_CODE_LSB +: CMD_CODE_W] == CMD_MAIL_POST)
                next_cur.pin_addr = mailbox_addr(1'b0);
            end
            CMD_MEM_READ, CMD_MAIL_TAKE:
            begin
              next_cur.is_write = 1'b0;
              next_cur.is_token = 1'b0;
              if (reg_wdata[CMD_CODE_LSB +: CMD_CODE_W] == CMD_MAIL_TAKE)
                next_cur.pin_addr = mailbox_addr(1'b1);
            end
            default:
            begin
              next_cur.is_token = 1'b1;
              next_cur.is_write = (reg_wdata[CMD_CODE_LSB +: CMD_CODE_W] != CMD_TOKEN_READ);
              next_cur.read_back = (reg_wdata[CMD_CODE_LSB +: CMD_CODE_W] == CMD_TOKEN_TAKE);
              next_cur.take = next_cur.read_back;
              next_cur.dout = {DW{~next_cur.read_back}};
              next_cur.dout_oe = next_cur.is_write;
              next_cur.ub_n = 1'b1;
              next_cur.lb_n = 1'b1;
              next_cur.pin_addr = AW'(cur.addr_r[TOKEN_IDX_W-1:0]);
            end
          endcase
          next_cur.ce_n = next_cur.is_token;
          next_cur.sem_n = ~next_cur.is_token;
          next_cur.cnt = next_cur.is_token ? SETUP_CYC : SETTLE_CYC;
        end
      end

      DPAS_SETTLE:
      begin
        if (cur.cnt > CNT_ONE)
          next_cur.cnt = cur.cnt - CNT_ONE;
        else if (!cur.is_token && !busy_n_s)
          next_cur.contended = 1'b1;
        else
        begin
          next_cur.st = DPAS_STROBE;
          next_cur.cnt = STROBE_CYC;
          next_cur.rw_n = ~cur.is_write;
          next_cur.oe_n = cur.is_write;
        end
      end

      DPAS_STROBE:
      begin
        if (cur.cnt > CNT_ONE)
          next_cur.cnt = cur.cnt - CNT_ONE;
        else
        begin
          next_cur.st = DPAS_RELEASE;
          next_cur.rw_n = 1'b1;
          next_cur.oe_n = 1'b1;
          if (!cur.is_write)
          begin
            next_cur.rdata_r = din_s;
            if (cur.is_token)
              next_cur.token = ~din_s[0];
          end
          else if (cur.is_token && !cur.take)
            next_cur.token = 1'b0;
        end
      end

      DPAS_RELEASE:
      begin
        next_cur.st = DPAS_RECOVER;
        next_cur.ce_n = 1'b1;
        next_cur.sem_n = 1'b1;
        next_cur.cnt = RECOVER_CYC;
      end

      DPAS_RECOVER:
      begin
        next_cur.dout_oe = 1'b0;
        if (cur.cnt > CNT_ONE)
          next_cur.cnt = cur.cnt - CNT_ONE;
        else if (cur.read_back)
        begin
          // Claim written; verify ownership by reading the latch back
          next_cur.st = DPAS_SETTLE;
          next_cur.read_back = 1'b0;
          next_cur.is_write = 1'b0;
          next_cur.sem_n = 1'b0;
          next_cur.cnt = SETUP_CYC;
        end
        else
        begin
          next_cur.st = DPAS_IDLE;
          next_cur.done = 1'b1;
        end
      end

      default:
        next_cur.st = DPAS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur <= '0;
      cur.st <= DPAS_IDLE;
      cur.bytes_r <= BYTES_RESET;
      cur.ce_n <= 1'b1;
      cur.rw_n <= 1'b1;
      cur.oe_n <= 1'b1;
      cur.ub_n <= 1'b1;
      cur.lb_n <= 1'b1;
      cur.sem_n <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  assign reg_rdata = cur.bus_rdata;
  assign chip_select_n = cur.ce_n;
  assign read_write_n = cur.rw_n;
  assign output_enable_n = cur.oe_n;
  assign upper_byte_select_n = cur.ub_n;
  assign lower_byte_select_n = cur.lb_n;
  assign token_latch_select_n = cur.sem_n;
  assign mem_addr = cur.pin_addr;
  assign mem_data_out = cur.dout;
  assign mem_data_oe = cur.dout_oe;

endmodule // dpas_port_ctrl

`default_nettype wire

/* rtl/dpas_unused_placeholder_never.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* tb/dpas_port_ctrl_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dpas_port_ctrl_assertions #(
  parameter int DW = 16,
  parameter int AW = 13
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Device pins
  input wire logic chip_select_n,
  input wire logic read_write_n,
  input wire logic output_enable_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic token_latch_select_n,
  input wire logic [AW-1:0] mem_addr,
  input wire logic mem_data_oe,
  input wire logic contention_flag_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_token_alone;
    !token_latch_select_n |-> chip_select_n;
  endproperty
  a_token_alone: assert property (p_token_alone) else $error("chip select low during token access");
  property p_token_lanes;
    !token_latch_select_n |-> upper_byte_select_n && lower_byte_select_n;
  endproperty
  a_token_lanes: assert property (p_token_lanes) else $error("byte select low during token access");
  property p_token_index;
    !token_latch_select_n |-> mem_addr[AW-1:3] == '0;
  endproperty
  a_token_index: assert property (p_token_index) else $error("high address bits set on token access");
  property p_settle;
    $fell(chip_select_n) |-> (read_write_n && output_enable_n)[*6];
  endproperty
  a_settle: assert property (p_settle) else $error("strobe before flag settle time");
  property p_hold_contended;
    (!chip_select_n && read_write_n && output_enable_n && !contention_flag_n)[*3] |=> read_write_n && output_enable_n;
  endproperty
  a_hold_contended: assert property (p_hold_contended) else $error("strobe during contention");
  property p_write_len;
    $fell(read_write_n) |=> (!read_write_n)[*8] ##1 read_write_n;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write strobe length wrong");
  property p_write_drives;
    !read_write_n |-> mem_data_oe && output_enable_n;
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("write without data drive");
  property p_read_floats;
    !output_enable_n |-> !mem_data_oe && read_write_n;
  endproperty
  a_read_floats: assert property (p_read_floats) else $error("read while driving data");
  property p_recover;
    $rose(token_latch_select_n) |-> token_latch_select_n[*3];
  endproperty
  a_recover: assert property (p_recover) else $error("token select recovery too short");
endmodule  // dpas_port_ctrl_assertions
bind dpas_port_ctrl dpas_port_ctrl_assertions #(.DW(DW), .AW(AW)) u_dpas_port_ctrl_assertions (
  .core_clk(core_clk), .nrst(nrst), .chip_select_n(chip_select_n), .read_write_n(read_write_n),
  .output_enable_n(output_enable_n), .upper_byte_select_n(upper_byte_select_n),
  .lower_byte_select_n(lower_byte_select_n), .token_latch_select_n(token_latch_select_n),
  .mem_addr(mem_addr), .mem_data_oe(mem_data_oe), .contention_flag_n(contention_flag_n));
`default_nettype wire

/* tb/dpas_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpas_dev_model #(
  parameter int DW = 16,
  parameter int AW = 13
) (
  // Control pins
  input wire logic chip_select_n,
  input wire logic read_write_n,
  input wire logic output_enable_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic token_latch_select_n,
  input wire logic [AW-1:0] mem_addr,
  input wire logic [DW-1:0] mem_data_out,
  // Other port contention request
  input wire logic busy_req,
  // Flags and data back
  output logic [DW-1:0] mem_data_in,
  output logic contention_flag_n,
  output logic mailbox_flag_n
);
  logic [DW-1:0] mem [logic [AW-1:0]];
  logic [1:0] own [8] = '{default: 2'h0};
  logic [7:0] req [2] = '{default: 8'h0};
  logic int_l = 1'b1;
  logic int_r = 1'b1;
  logic [DW-1:0] rd_q = '0;
  logic [DW-1:0] lanes;
  logic drv;
  // Owner code 1 is this port, 2 the far port
  task automatic sem_wr(input logic left, input logic [2:0] i, input logic v);
    logic [1:0] me;
    me = left ? 2'h1 : 2'h2;
    if (!v && own[i] == 2'h0)
      own[i] = me;
    else if (!v && own[i] != me)
      req[me-1][i] = 1'b1;
    else if (v && own[i] == me)
      own[i] = req[2-me][i] ? 2'h3 - me : 2'h0;
    if (v)
      req[me-1][i] = 1'b0;
    if (own[i] == 2'h3 - me)
      req[2-me][i] = 1'b0;
  endtask
  assign lanes = token_latch_select_n ? {{DW/2{~upper_byte_select_n}}, {DW/2{~lower_byte_select_n}}} : '1;
  always @(posedge read_write_n)
  begin
    if (!token_latch_select_n)
      sem_wr(1'b1, mem_addr[2:0], mem_data_out[0]);
    else if (!chip_select_n && contention_flag_n)
    begin
      mem[mem_addr] = (mem[mem_addr] & ~lanes) | (mem_data_out & lanes);
      if (mem_addr == '1)
        int_r = 1'b0;
    end
  end
  always @(negedge output_enable_n)
  begin
    if (!token_latch_select_n)
      rd_q = {DW{own[mem_addr[2:0]] != 2'h1}};
    else
      rd_q = mem[mem_addr];
    if (token_latch_select_n && contention_flag_n && mem_addr == {{AW-1{1'b1}}, 1'b0})
      int_l = 1'b1;
  end
  // Released or deselected lanes show the inverse of the last word
  assign drv = !output_enable_n && read_write_n && (!chip_select_n || !token_latch_select_n);
  assign mem_data_in = drv ? rd_q ^ ~lanes : ~rd_q;
  assign #2 contention_flag_n = !(busy_req && !chip_select_n);
  assign mailbox_flag_n = int_l;
endmodule  // dpas_dev_model
`default_nettype wire

/* tb/dual_port_arbiter_semaphore_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module dual_port_arbiter_semaphore_test;
  import dpas_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic busy_req = 1'b0;
  logic [31:0] reg_rdata, d;
  logic cs_n, rw_n, oe_n, ub_n, lb_n, sem_n, data_oe, flag_n, mail_n;
  logic [12:0] addr;
  logic [15:0] dout, din;
  int n_errors = 0;
  int n_checks = 0;
  dpas_port_ctrl u_dpas_port_ctrl (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chip_select_n(cs_n), .read_write_n(rw_n),
    .output_enable_n(oe_n), .upper_byte_select_n(ub_n), .lower_byte_select_n(lb_n),
    .token_latch_select_n(sem_n), .mem_addr(addr), .mem_data_out(dout), .mem_data_oe(data_oe),
    .mem_data_in(din), .contention_flag_n(flag_n), .mailbox_flag_n(mail_n));
  dpas_dev_model u_dpas_dev_model (
    .chip_select_n(cs_n), .read_write_n(rw_n), .output_enable_n(oe_n), .upper_byte_select_n(ub_n),
    .lower_byte_select_n(lb_n), .token_latch_select_n(sem_n), .mem_addr(addr), .mem_data_out(dout),
    .busy_req(busy_req), .mem_data_in(din), .contention_flag_n(flag_n), .mailbox_flag_n(mail_n));
  initial
    forever #2.5 core_clk = ~core_clk;
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    rd(REG_STATUS);
    while (d[ST_DONE] !== 1'b1 && k < 100)
    begin
      rd(REG_STATUS);
      k++;
    end
    `CHK("done", 1'b1, d[ST_DONE])
  endtask
  task automatic run(input logic [2:0] c);
    wr(REG_CMD, {29'h0, c});
    wait_done();
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    conclude();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    `CHK("cs_n", 1'b1, cs_n)
    `CHK("data_oe", 1'b0, data_oe)
    rd(REG_BYTES);
    `CHK("bytes", 32'h3, d)
    rd(4'hF);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
    wr(REG_ADDR, 32'h5);
    wr(REG_WDATA, 32'h1234);
    run(CMD_MEM_WRITE);
    wr(REG_BYTES, 32'h1);
    wr(REG_WDATA, 32'hABCD);
    run(CMD_MEM_WRITE);
    `CHK("mem", 16'h12CD, u_dpas_dev_model.mem[13'h5])
    wr(REG_BYTES, 32'h3);
    run(CMD_MEM_READ);
    rd(REG_RDATA);
    `CHK("rdata", 32'h12CD, d)
    $display("test memory done");
    u_dpas_dev_model.sem_wr(1'b0, 3'h2, 1'b0);
    wr(REG_ADDR, 32'h1FFA);
    run(CMD_TOKEN_TAKE);
    rd(REG_RDATA);
    `CHK("token_word", 32'hFFFF, d)
    rd(REG_STATUS);
    `CHK("token_busy", 1'b0, d[ST_TOKEN])
    u_dpas_dev_model.sem_wr(1'b0, 3'h2, 1'b1);
    run(CMD_TOKEN_READ);
    rd(REG_STATUS);
    `CHK("token_handed", 1'b1, d[ST_TOKEN])
    run(CMD_TOKEN_GIVE);
    `CHK("token_free", 2'h0, u_dpas_dev_model.own[2])
    wr(REG_ADDR, 32'h3);
    run(CMD_TOKEN_TAKE);
    rd(REG_RDATA);
    `CHK("token_own", 32'h0, d)
    `CHK("token_side", 2'h1, u_dpas_dev_model.own[3])
    $display("test token done");
    wr(REG_WDATA, 32'h55AA);
    run(CMD_MAIL_POST);
    `CHK("mail_out", 1'b0, u_dpas_dev_model.int_r)
    u_dpas_dev_model.int_l = 1'b0;
    repeat (3) @(posedge core_clk);
    rd(REG_STATUS);
    `CHK("mail_in", 1'b1, d[ST_MAIL])
    run(CMD_MAIL_TAKE);
    rd(REG_STATUS);
    `CHK("mail_taken", 1'b0, d[ST_MAIL])
    $display("test mailbox done");
    busy_req <= 1'b1;
    wr(REG_WDATA, 32'h0F0F);
    wr(REG_CMD, {29'h0, CMD_MEM_WRITE});
    repeat (30) @(posedge core_clk);
    `CHK("held", 1'b1, rw_n)
    `CHK("held_select", 1'b0, cs_n)
    rd(REG_STATUS);
    `CHK("running", 1'b1, d[ST_RUN])
    busy_req <= 1'b0;
    wait_done();
    `CHK("contended", 1'b1, d[ST_CONTEND])
    `CHK("mem_late", 16'h0F0F, u_dpas_dev_model.mem[13'h3])
    $display("test contention done");
    wr(REG_BYTES, 32'h0);
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd(REG_STATUS);
    `CHK("status_reset", 32'h0, d)
    rd(REG_BYTES);
    `CHK("bytes_reset", 32'h3, d)
    $display("test reset again done");
    conclude();
  end
endmodule  // dual_port_arbiter_semaphore_test
`default_nettype wire
